/* File: include/psif_pkg.sv */
// Constants, register map and field layout of the serial PCM input block.
// Assumes a 32-bit AHB-Lite register bus and a link clock from the source.
//
// Notes on behaviour
// - format codes pick standard, left or right justified
// - right-first bit swaps which word is left
// - frame code sets 64, 48 or 32 clocks
// - bit order selects MSB-first or LSB-first words
// - polarity bit picks word select level of first word
package psif_pkg;

  // ***********************************************************
  // Register indices; byte address is four times the index
  // ***********************************************************
  localparam logic [7:0] PSIF_IDX_WORD_FMT   = 8'h35;
  localparam logic [7:0] PSIF_IDX_FRAME      = 8'h36;
  localparam logic [7:0] PSIF_IDX_LEFT       = 8'h37;
  localparam logic [7:0] PSIF_IDX_RIGHT      = 8'h38;
  localparam logic [7:0] PSIF_IDX_STATUS     = 8'h39;
  localparam logic [7:0] PSIF_RST_WORD_FMT   = 8'h01;
  localparam logic [7:0] PSIF_RST_FRAME      = 8'h01;
  localparam logic [2:0] PSIF_HSIZE_WORD     = 3'h2;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int PSIF_FMT_LSB     = 0;
  localparam int PSIF_RFIRST_BIT  = 5;
  localparam int PSIF_FSIZE_LSB   = 3;
  localparam int PSIF_ORDER_BIT   = 2;
  localparam int PSIF_WSPOL_BIT   = 1;
  localparam int PSIF_EDGE_BIT    = 0;
  localparam int PSIF_STAT_PEND   = 0;
  localparam int PSIF_STAT_SEEN   = 1;

  // ***********************************************************
  // Word layout and frame codes, lengths in bit clocks
  // ***********************************************************
  localparam logic [2:0] PSIF_FMT_STD  = 3'h0;
  localparam logic [2:0] PSIF_FMT_LJ   = 3'h1;
  localparam logic [2:0] PSIF_FMT_RJ16 = 3'h4;
  localparam logic [2:0] PSIF_FMT_RJ20 = 3'h5;
  localparam logic [2:0] PSIF_FMT_RJ18 = 3'h6;
  localparam logic [2:0] PSIF_FMT_RJ24 = 3'h7;
  localparam logic [1:0] PSIF_FRM_64   = 2'h0;
  localparam logic [1:0] PSIF_FRM_48   = 2'h1;
  localparam logic [1:0] PSIF_FRM_32   = 2'h2;
  localparam logic [5:0] PSIF_HALF_64  = 6'h20;
  localparam logic [5:0] PSIF_HALF_48  = 6'h18;
  localparam logic [5:0] PSIF_HALF_32  = 6'h10;
  localparam logic [5:0] PSIF_SAMPLE_W = 6'h18;

  // Byte address of a register index
  function automatic logic [7:0] psif_addr(input logic [7:0] idx);
    psif_addr = {idx[5:0], 2'b00};
  endfunction : psif_addr

endpackage : psif_pkg

/* File: include/psif_reg_if.sv */
// Carrier between the register slave and the receiver core.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
interface psif_reg_if;
  logic [7:0]  fmtReg;
  logic [7:0]  frmReg;
  logic        cfgWrite;
  logic [23:0] leftWord;
  logic [23:0] rightWord;
  logic        cfgPending;
  logic        pairSeen;

  modport regs (output fmtReg, frmReg, cfgWrite,
                input  leftWord, rightWord, cfgPending, pairSeen);
  modport core (input  fmtReg, frmReg, cfgWrite,
                output leftWord, rightWord, cfgPending, pairSeen);
endinterface : psif_reg_if

/* File: src/psif_regs.sv */
// AHB-Lite slave holding the format registers of the PCM input.
// Assumes one slave on the bus, word transfers only, zero wait states.
`timescale 1ns/100ps
module psif_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  psif_reg_if.regs         bus
);

  logic       wrPend;
  logic [7:0] wrAddr;

  // Address phase decode
  wire        addrPh  = hsel & hready & htrans[1];
  wire        rdTake  = addrPh & ~hwrite;
  wire        wrTake  = addrPh & hwrite & (hsize == psif_pkg::PSIF_HSIZE_WORD);
  wire [7:0]  aLow    = haddr[7:0];
  wire        upperOk = (haddr[31:8] == 24'h000000);
  wire        wrFmt   = wrPend &
                        (wrAddr == psif_pkg::psif_addr(psif_pkg::PSIF_IDX_WORD_FMT));
  wire        wrFrm   = wrPend &
                        (wrAddr == psif_pkg::psif_addr(psif_pkg::PSIF_IDX_FRAME));

  // Read selection; unmapped addresses read zero
  wire [31:0] rdMux =
    !upperOk ? 32'h00000000 :
    (aLow == psif_pkg::psif_addr(psif_pkg::PSIF_IDX_WORD_FMT)) ?
      {24'h000000, bus.fmtReg} :
    (aLow == psif_pkg::psif_addr(psif_pkg::PSIF_IDX_FRAME)) ?
      {24'h000000, bus.frmReg} :
    (aLow == psif_pkg::psif_addr(psif_pkg::PSIF_IDX_LEFT)) ?
      {8'h00, bus.leftWord} :
    (aLow == psif_pkg::psif_addr(psif_pkg::PSIF_IDX_RIGHT)) ?
      {8'h00, bus.rightWord} :
    (aLow == psif_pkg::psif_addr(psif_pkg::PSIF_IDX_STATUS)) ?
      {30'h00000000, bus.pairSeen, bus.cfgPending} : 32'h00000000;

  // Bus handshake and captured write address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend    <= wrTake & upperOk;
      wrAddr    <= aLow;
      hrdata    <= rdTake ? rdMux : 32'h00000000;
    end
  end

  // Format registers, written in the data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.fmtReg   <= psif_pkg::PSIF_RST_WORD_FMT;
      bus.frmReg   <= psif_pkg::PSIF_RST_FRAME;
      bus.cfgWrite <= 1'b0;
    end else begin
      if (wrFmt) bus.fmtReg <= hwdata[7:0];
      if (wrFrm) bus.frmReg <= hwdata[7:0];
      bus.cfgWrite <= wrFmt | wrFrm;
    end
  end

endmodule : psif_regs

/* File: src/psif_top.sv */
// Serial PCM audio input receiver with AHB-Lite format registers.
// Assumes the source drives bit clock, word select and data together;
// the bit clock may stop between streams.
`timescale 1ns/100ps
module psif_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        bitClk,
  input  wire logic        pairSelect,
  input  wire logic        serialDataIn,
  output logic      [23:0] sampleLeft,
  output logic      [23:0] sampleRight,
  output logic             sampleValid
);

  // ***********************************************************
  // Helper functions
  // ***********************************************************

  // Half-frame length from the frame code
  function automatic logic [5:0] halfLen(input logic [1:0] code);
    case (code)
      psif_pkg::PSIF_FRM_48: halfLen = psif_pkg::PSIF_HALF_48;
      psif_pkg::PSIF_FRM_32: halfLen = psif_pkg::PSIF_HALF_32;
      default:               halfLen = psif_pkg::PSIF_HALF_64;
    endcase
  endfunction : halfLen

  // Word length from format, clipped to the half-frame
  function automatic logic [5:0] wordLen(input logic [2:0] fmt,
                                         input logic [5:0] half);
    logic [5:0] w;
    w = psif_pkg::PSIF_SAMPLE_W;
    case (fmt)
      psif_pkg::PSIF_FMT_RJ16: w = 6'h10;
      psif_pkg::PSIF_FMT_RJ18: w = 6'h12;
      psif_pkg::PSIF_FMT_RJ20: w = 6'h14;
      psif_pkg::PSIF_FMT_RJ24: w = 6'h18;
      default:                 w = psif_pkg::PSIF_SAMPLE_W;
    endcase
    wordLen = (w > half) ? half : w;
  endfunction : wordLen

  // ***********************************************************
  // Register slave
  // ***********************************************************
  psif_reg_if regBus ();

  psif_regs u_regs (
    .clk       (clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .bus       (regBus.regs)
  );

  // ***********************************************************
  // System side of the configuration crossing
  // ***********************************************************
  logic [7:0] cfgFmt;
  logic [7:0] cfgFrm;
  logic       cfgReq;
  logic       cfgDirty;
  logic       ackS1;
  logic       ackS2;
  logic       reqS3;

  wire cfgIdle   = (cfgReq == ackS2);
  wire cfgLaunch = cfgDirty & cfgIdle;
  wire next_cfgDirty = regBus.cfgWrite | (cfgDirty & ~cfgLaunch);

  // Ack toggle back from the link domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
    end else begin
      ackS1 <= reqS3;
      ackS2 <= ackS1;
    end
  end

  // Held bundle stays still until the link acknowledges it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgFmt   <= psif_pkg::PSIF_RST_WORD_FMT;
      cfgFrm   <= psif_pkg::PSIF_RST_FRAME;
      cfgReq   <= 1'b0;
      cfgDirty <= 1'b0;
    end else begin
      cfgDirty <= next_cfgDirty;
      if (cfgLaunch) begin
        cfgFmt <= regBus.fmtReg;
        cfgFrm <= regBus.frmReg;
        cfgReq <= ~cfgReq;
      end
    end
  end

  assign regBus.cfgPending = cfgDirty | ~cfgIdle;

  // ***********************************************************
  // Link domain reset and request synchroniser
  // ***********************************************************
  logic linkRstQ1;
  logic linkRstQ2;
  logic reqS1;
  logic reqS2;

  // Reset asserts at once, releases on the bit clock
  always_ff @(posedge bitClk or posedge rst) begin
    if (rst) begin
      linkRstQ1 <= 1'b1;
      linkRstQ2 <= 1'b1;
    end else begin
      linkRstQ1 <= 1'b0;
      linkRstQ2 <= linkRstQ1;
    end
  end

  wire linkRst = linkRstQ2;

  // Request toggle into the link domain
  always_ff @(posedge bitClk or posedge linkRst) begin
    if (linkRst) begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
    end else begin
      reqS1 <= cfgReq;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
    end
  end

  wire reqEdge = reqS2 ^ reqS3;

  // ***********************************************************
  // Link domain active settings
  // ***********************************************************
  logic [7:0] pendFmt;
  logic [7:0] pendFrm;
  logic       hasPend;
  logic [7:0] actFmt;
  logic [7:0] actFrm;

  wire [2:0] fmt        = actFmt[psif_pkg::PSIF_FMT_LSB +: 3];
  wire       rightFirst = actFmt[psif_pkg::PSIF_RFIRST_BIT];
  wire [1:0] frmCode    = actFrm[psif_pkg::PSIF_FSIZE_LSB +: 2];
  wire       lsbFirst   = actFrm[psif_pkg::PSIF_ORDER_BIT];
  wire       firstLvl   = actFrm[psif_pkg::PSIF_WSPOL_BIT];
  wire       capRise    = actFrm[psif_pkg::PSIF_EDGE_BIT];

  // Format decode
  wire isRj  = fmt[2];
  wire isLj  = (fmt == psif_pkg::PSIF_FMT_LJ);
  wire isStd = ~isRj & ~isLj;

  // ***********************************************************
  // Capture of data and word select
  // ***********************************************************
  logic fallData;
  logic fallWs;
  logic wsD1;
  logic alignPrev;

  // Falling-edge samples, used by the rising-edge logic
  always_ff @(negedge bitClk or posedge linkRst) begin
    if (linkRst) begin
      fallData <= 1'b0;
      fallWs   <= 1'b0;
    end else begin
      fallData <= serialDataIn;
      fallWs   <= pairSelect;
    end
  end

  // Pick the capture edge
  wire sdBit = capRise ? serialDataIn : fallData;
  wire wsBit = capRise ? pairSelect : fallWs;

  // Standard layout lags word select by one bit clock
  wire alignWs = isStd ? wsD1 : wsBit;
  wire wsEdge  = alignWs ^ alignPrev;
  wire prevWasFirst = (alignPrev == firstLvl);
  wire frameStart   = wsEdge & (alignWs == firstLvl);

  // ***********************************************************
  // Bit position within the half-frame
  // ***********************************************************
  logic [5:0]  cnt;
  logic [23:0] acc;

  wire [5:0] half   = halfLen(frmCode);
  wire [5:0] wLen   = wordLen(fmt, half);
  wire [5:0] start  = isRj ? (half - wLen) : 6'h00;
  wire [5:0] curIdx = wsEdge ? 6'h00 : cnt;
  wire [6:0] winEnd = {1'b0, start} + {1'b0, wLen};
  wire       inWin  = (curIdx >= start) & ({1'b0, curIdx} < winEnd);
  wire [5:0] next_cnt = (curIdx == 6'h3f) ? curIdx : curIdx + 6'h01;

  // Shift in the word in the chosen bit order
  wire [23:0] accBase = wsEdge ? 24'h000000 : acc;
  wire [23:0] next_acc =
    !inWin   ? accBase :
    lsbFirst ? {sdBit, accBase[23:1]} :
               {accBase[22:0], sdBit};

  // Finished word, aligned so its top bit sits at bit 23
  wire [5:0]  padBits  = psif_pkg::PSIF_SAMPLE_W - wLen;
  wire [23:0] doneWord = lsbFirst ? acc : (acc << padBits);

  always_ff @(posedge bitClk or posedge linkRst) begin
    if (linkRst) begin
      wsD1      <= 1'b0;
      alignPrev <= 1'b0;
      cnt       <= 6'h00;
      acc       <= 24'h000000;
    end else begin
      wsD1      <= wsBit;
      alignPrev <= alignWs;
      cnt       <= next_cnt;
      acc       <= next_acc;
    end
  end

  // ***********************************************************
  // Settings swap at frame start
  // ***********************************************************
  always_ff @(posedge bitClk or posedge linkRst) begin
    if (linkRst) begin
      pendFmt <= psif_pkg::PSIF_RST_WORD_FMT;
      pendFrm <= psif_pkg::PSIF_RST_FRAME;
      hasPend <= 1'b0;
      actFmt  <= psif_pkg::PSIF_RST_WORD_FMT;
      actFrm  <= psif_pkg::PSIF_RST_FRAME;
    end else begin
      if (frameStart & hasPend) begin
        actFmt <= pendFmt;
        actFrm <= pendFrm;
      end
      if (reqEdge) begin
        pendFmt <= cfgFmt;
        pendFrm <= cfgFrm;
      end
      hasPend <= reqEdge | (hasPend & ~frameStart);
    end
  end

  // ***********************************************************
  // Pair assembly and channel assignment
  // ***********************************************************
  logic [23:0] firstWord;
  logic [23:0] pairLeft;
  logic [23:0] pairRight;
  logic        pairTgl;

  always_ff @(posedge bitClk or posedge linkRst) begin
    if (linkRst) begin
      firstWord <= 24'h000000;
      pairLeft  <= 24'h000000;
      pairRight <= 24'h000000;
      pairTgl   <= 1'b0;
    end else if (wsEdge) begin
      if (prevWasFirst) begin
        firstWord <= doneWord;
      end else begin
        pairLeft  <= rightFirst ? doneWord : firstWord;
        pairRight <= rightFirst ? firstWord : doneWord;
        pairTgl   <= ~pairTgl;
      end
    end
  end

  // ***********************************************************
  // Pair hand-over into the system domain
  // ***********************************************************
  logic tglS1;
  logic tglS2;
  logic tglS3;
  logic seen;

  wire pairArrive = tglS2 ^ tglS3;

  // Toggle synchroniser; words are stable for a whole frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tglS1 <= 1'b0;
      tglS2 <= 1'b0;
      tglS3 <= 1'b0;
    end else begin
      tglS1 <= pairTgl;
      tglS2 <= tglS1;
      tglS3 <= tglS2;
    end
  end

  // Output sample registers and valid strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampleLeft  <= 24'h000000;
      sampleRight <= 24'h000000;
      sampleValid <= 1'b0;
      seen        <= 1'b0;
    end else begin
      sampleValid <= pairArrive;
      seen        <= seen | pairArrive;
      if (pairArrive) begin
        sampleLeft  <= pairLeft;
        sampleRight <= pairRight;
      end
    end
  end

  // Read-back of the latest pair and link status
  assign regBus.leftWord  = sampleLeft;
  assign regBus.rightWord = sampleRight;
  assign regBus.pairSeen  = seen;

endmodule : psif_top

/* File: tb/psif_source.sv */
// Behavioural audio source driving bit clock, word select and data.
// Assumes tasks are called from the bench; clock stands still between.
`timescale 1ns/100ps
module psif_source (
  output logic bitClk,
  output logic pairSelect,
  output logic serialDataIn
);
  logic edgeSel = 1'b1;
  logic carry   = 1'b0;
  initial begin
    bitClk = 1'b1;
    pairSelect = 1'b1;
    serialDataIn = 1'b0;
  end

  // One bit: launch on the change edge, hold across the capture edge
  task automatic sendBit(input logic ws, input logic d);
    bitClk = !edgeSel;
    pairSelect = ws;
    serialDataIn = d;
    #3;
    bitClk = edgeSel;
    #3;
  endtask : sendBit

  // Free clocks with toggling data, used during reset
  task automatic runClock(input int n);
    repeat (n) sendBit(pairSelect, !serialDataIn);
  endtask : runClock

  // One word select half; filler bits toggle so stale data never matches
  task automatic sendHalf(input logic [23:0] w, input int n, half, just,
                          input logic lsb, ws);
    int k;
    for (int j = 0; j < half; j++) begin
      k = (just == 2) ? j - (half - n) : j - int'(just == 0);
      if (k >= 0 && k < n) sendBit(ws, lsb ? w[24-n+k] : w[23-k]);
      else if (j == 0 && just == 0) sendBit(ws, carry);
      else sendBit(ws, j[0]);
    end
    // Standard layout: a full-length word spills its last bit over
    carry = (just == 0 && n == half) ? (lsb ? w[23] : w[24-n]) : 1'b0;
  endtask : sendHalf

  // Whole frame: first word at the polarity level, second at the other
  task automatic sendFrame(input logic [23:0] a, b, input int n, half,
                           just, input logic lsb, pol, edg);
    edgeSel = edg;
    sendHalf(a, n, half, just, lsb, pol);
    sendHalf(b, n, half, just, lsb, !pol);
  endtask : sendFrame

  // Start of a new frame, which closes the previous pair
  task automatic tail(input logic pol);
    sendBit(pol, carry);
    repeat (3) sendBit(pol, 1'b0);
    carry = 1'b0;
  endtask : tail
endmodule : psif_source

/* File: tb/psif_top_properties.sv */
// Concurrent checks on the ports of the serial PCM input top.
// Assumes it is bound to psif_top and sees only its ports.
`timescale 1ns/100ps
module psif_top_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [23:0] sampleLeft,
  input wire logic [23:0] sampleRight,
  input wire logic        sampleValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Decoded address phases
  wire take   = hsel && hready && htrans[1];
  wire rdTake = take && !hwrite;
  wire wrFmt  = take && hwrite && hsize == 3'h2 && haddr == 32'hd4;
  wire rdFmt  = rdTake && haddr == 32'hd4;
  wire rdLeft = rdTake && haddr == 32'hdc;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  sequence seqFmtWrRd;
    wrFmt ##2 rdFmt;
  endsequence
  sequence seqQuietRead;
    rdLeft && !sampleValid ##1 !sampleValid;
  endsequence

  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout dropped");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_idle_zero: assert property (!rdTake |=> hrdata == 32'h0)
    else $error("hrdata not zero outside read");
  chk_unmapped_zero: assert property
    (rdTake && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_fmt_readback: assert property
    (seqFmtWrRd |=> hrdata == {24'h0, $past(hwdata[7:0], 2)})
    else $error("format register readback wrong");
  chk_left_read: assert property
    (seqQuietRead |-> hrdata == {8'h0, $past(sampleLeft)})
    else $error("left sample read wrong");
  chk_valid_pulse: assert property (sampleValid |=> !sampleValid)
    else $error("sample valid longer than one cycle");
  chk_sample_hold: assert property
    ($changed(sampleLeft) || $changed(sampleRight) |-> sampleValid)
    else $error("sample changed without valid");
  cov_pair: cover property (sampleValid);
endmodule : psif_top_properties

bind psif_top psif_top_properties chk (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sampleLeft(sampleLeft),
  .sampleRight(sampleRight), .sampleValid(sampleValid));

/* File: tb/psif_top_test.sv */
// Self-checking bench of the serial PCM input top.
// Assumes the AHB-Lite slave is alone on the bus and a source model.
`timescale 1ns/100ps
module psif_top_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, sampleValid;
  logic        bitClk, pairSelect, serialDataIn;
  logic [23:0] sampleLeft, sampleRight, gotL, gotR, wl, wr;
  logic [31:0] lfsrState = 32'h2c70;
  logic [31:0] rd;
  logic [7:0]  fmtVal [8] = '{8'h01, 8'h00, 8'h04, 8'h06, 8'h05, 8'h27,
                             8'h21, 8'h01};
  logic [7:0]  frmVal [8] = '{8'h01, 8'h12, 8'h09, 8'h00, 8'h03, 8'h0d,
                             8'h06, 8'h19};
  int          badCount = 0;
  int          nTests = 0;
  int          pulses = 0;
  int          half, n, just;

  psif_top DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .bitClk(bitClk), .pairSelect(pairSelect),
    .serialDataIn(serialDataIn), .sampleLeft(sampleLeft),
    .sampleRight(sampleRight), .sampleValid(sampleValid));
  psif_source src (.bitClk(bitClk), .pairSelect(pairSelect),
    .serialDataIn(serialDataIn));

  // System clock, 40 ns period
  initial forever #20 clk = ~clk;

  // Catch each published pair
  always @(posedge clk) begin
    if (sampleValid === 1'b1) begin
      gotL <= sampleLeft;
      gotR <= sampleRight;
      pulses <= pulses + 1;
    end
  end

  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic [23:0] rand24();
    repeat (8) lfsrState = {lfsrState[30:0],
      lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState[23:0];
  endfunction : rand24

  // Expected word: top n bits kept, low bits zero
  function automatic logic [23:0] expWord(input logic [23:0] r,
                                          input int bits);
    return r & (24'hffffff << (24 - bits));
  endfunction : expWord

  task automatic finishTest(input bit hung);
    if (hung) badCount++;
    if (badCount == 0 && nTests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finishTest

  task automatic check(input logic [31:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait for hready at a rising edge
  task automatic waitReady();
    int t;
    t = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      t++;
      if (t > 50) finishTest(1'b1);
      @(posedge clk);
    end
  endtask : waitReady

  task automatic busWrite(input logic [31:0] a, d, input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsize <= sz;
    waitReady();
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
  endtask : busWrite

  task automatic busRead(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    waitReady();
    htrans <= 2'h0;
    waitReady();
    d = hrdata;
  endtask : busRead

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    fork
      begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
      end
      src.runClock(20);
    join
    @(posedge clk);
    busRead(32'hd4, rd);
    check(rd, 32'h01);
    busRead(32'hd8, rd);
    check(rd, 32'h01);
    busRead(32'h1d4, rd);
    check(rd, 32'h0);
    for (int s = 0; s < 8; s++) begin
      busWrite(32'hd4, {24'h0, fmtVal[s]}, 3'h2);
      busRead(32'hd4, rd);
      check(rd, {24'h0, fmtVal[s]});
      busWrite(32'hd4, 32'hff, 3'h0);
      busRead(32'hd4, rd);
      check(rd, {24'h0, fmtVal[s]});
      busWrite(32'hd8, {24'h0, frmVal[s]}, 3'h2);
      busRead(32'hd8, rd);
      check(rd, {24'h0, frmVal[s]});
      half = frmVal[s][4:3] == 2'h1 ? 24 : frmVal[s][4:3] == 2'h2 ? 16 : 32;
      just = fmtVal[s][2] ? 2 : int'(fmtVal[s][2:0] == 3'h1);
      n = !fmtVal[s][2] ? (half < 24 ? half : 24) : fmtVal[s][1:0] == 2'h0
        ? 16 : fmtVal[s][1:0] == 2'h1 ? 20 : fmtVal[s][0] ? 24 : 18;
      wl = rand24();
      wr = rand24();
      // Two throwaway frames, so a polarity change has settled fully
      repeat (2)
        src.sendFrame(rand24(), rand24(), n, half, just, frmVal[s][2],
                      frmVal[s][1], frmVal[s][0]);
      src.sendFrame(fmtVal[s][5] ? wr : wl, fmtVal[s][5] ? wl : wr,
                    n, half, just, frmVal[s][2], frmVal[s][1], frmVal[s][0]);
      repeat (8) @(posedge clk);
      pulses = 0;
      src.tail(frmVal[s][1]);
      for (int t = 0; pulses == 0; t++) begin
        if (t > 40) finishTest(1'b1);
        @(posedge clk);
      end
      check({8'h0, gotL}, {8'h0, expWord(wl, n)});
      check({8'h0, gotR}, {8'h0, expWord(wr, n)});
      busWrite(32'hdc, 32'hffffff, 3'h2);
      busRead(32'hdc, rd);
      check(rd, {8'h0, expWord(wl, n)});
      busRead(32'he0, rd);
      check(rd, {8'h0, expWord(wr, n)});
    end
    busRead(32'he4, rd);
    check({31'h0, rd[1]}, 32'h1);
    finishTest(1'b0);
  end
endmodule : psif_top_test
